// [design/fcsm_pkg.sv]
// Package of command codes, states and timing constants for the flash command state machine
package fcsm_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'h00_FF;
    localparam logic [7:0] CMD_PROG_SETUP_A = 8'h00_10;
    localparam logic [7:0] CMD_PROG_SETUP_B = 8'h00_40;
    localparam logic [7:0] CMD_BUF_SETUP = 8'h00_E8;
    localparam logic [7:0] CMD_BFP_SETUP = 8'h00_30;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h00_20;
    localparam logic [7:0] CMD_CONFIRM = 8'h00_D0;
    localparam logic [7:0] CMD_SUSPEND = 8'h00_B0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h00_70;
    localparam logic [7:0] CMD_READ_ID = 8'h00_90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h00_98;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h00_60;
    localparam logic [7:0] CMD_OTP_SETUP = 8'h00_C0;
    localparam logic [7:0] CMD_LOCK_2ND_A = 8'h00_01;
    localparam logic [7:0] CMD_LOCK_2ND_B = 8'h00_2F;
    localparam logic [7:0] CMD_LOCK_2ND_C = 8'h00_03;

    // ==========================================================
    // Status bit positions and timing
    localparam int READY_BIT = 7;
    localparam int BUF_PROG_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00_80;
    localparam int PROG_TIME_NS = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PROG_CYCLES_W = 8'(PROG_CYCLES);

    // ==========================================================
    // Read data source
    typedef enum logic [1:0] {
        SRC_ARRAY = 2'b00,
        SRC_STATUS = 2'b01,
        SRC_CONFIG = 2'b11,
        SRC_QUERY = 2'b10
    } fcsm_src_t;

    // ==========================================================
    // States, Gray coded in the order listed, so setup -> busy -> done changes one bit per step
    typedef enum logic [3:0] {
        ST_READ_ARRAY = 4'b0000,
        ST_READ_STATUS = 4'b0001,
        ST_READ_CONFIG = 4'b0011,
        ST_READ_QUERY = 4'b0010,
        ST_LOCK_SETUP = 4'b0110,
        ST_BOTCH = 4'b0111,
        ST_OTP_SETUP = 4'b0101,
        ST_OTP_BUSY = 4'b0100,
        ST_OTP_DONE = 4'b1100,
        ST_PROG_SETUP = 4'b1101,
        ST_PROG_BUSY = 4'b1111,
        ST_PROG_DONE = 4'b1110,
        ST_PROG_SUSP = 4'b1010,
        ST_BUF_SETUP = 4'b1011,
        ST_BFP_SETUP = 4'b1001,
        ST_ERASE_SETUP = 4'b1000
    } fcsm_state_t;

endpackage : fcsm_pkg

// [design/fcsm_busy_timer.sv]
// Down counter that times an internal program operation
`timescale 1ns/1ps
`default_nettype none
module fcsm_busy_timer
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic start,
    input wire logic hold,
    output var logic done
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;

    // Hold freezes the count while the operation is suspended
    assign count_nxt = start ? fcsm_pkg::PROG_CYCLES_W :
                       (hold || count_r == 8'h00_00) ? count_r : count_r - 8'h00_01;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            count_r <= 8'h00_00;
        else
            count_r <= count_nxt;
    end

    assign done = (count_r == 8'h00_01) && !hold && !start;
endmodule : fcsm_busy_timer
`default_nettype wire

// [design/fcsm_top.sv]
// Command state machine: next-state decode and read-source selection
//
// Overview of operation
// RL1 - OTP busy ignores commands, reads status
// RL2 - OTP busy reports ready low
// RL3 - OTP done decodes like idle read
// RL4 - Bad lock second cycle goes to error
// RL5 - Error state reads ready status; E8 stays
// RL6 - Program busy honours only suspend
// RL7 - Reset clears status to idle read
`timescale 1ns/1ps
`default_nettype none
module fcsm_top
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Command write strobe and byte, same clock domain
    input wire logic CMD_WE,
    input wire logic [7:0] CMD_DATA,
    // Read source and status
    output logic [1:0] READ_SRC,
    output logic READY,
    output logic BUF_PROG_STATUS,
    output logic [3:0] STATE
);
    fcsm_pkg::fcsm_state_t state_r;
    fcsm_pkg::fcsm_state_t state_nxt;
    fcsm_pkg::fcsm_state_t idle_nxt;
    logic [1:0] src_nxt;
    logic ready_nxt;
    logic timer_done;
    logic timer_start;
    logic timer_hold;
    logic lock_ok;

    // ==========================================================
    // Command decode shared by every idle-like state
    function automatic fcsm_pkg::fcsm_state_t idle_decode(input logic [7:0] cmd,
                                                          input fcsm_pkg::fcsm_state_t cur);
        case (cmd)
            fcsm_pkg::CMD_READ_ARRAY: idle_decode = fcsm_pkg::ST_READ_ARRAY;
            fcsm_pkg::CMD_PROG_SETUP_A: idle_decode = fcsm_pkg::ST_PROG_SETUP;
            fcsm_pkg::CMD_PROG_SETUP_B: idle_decode = fcsm_pkg::ST_PROG_SETUP;
            fcsm_pkg::CMD_BUF_SETUP: idle_decode = fcsm_pkg::ST_BUF_SETUP;
            fcsm_pkg::CMD_BFP_SETUP: idle_decode = fcsm_pkg::ST_BFP_SETUP;
            fcsm_pkg::CMD_ERASE_SETUP: idle_decode = fcsm_pkg::ST_ERASE_SETUP;
            fcsm_pkg::CMD_CONFIRM: idle_decode = fcsm_pkg::ST_READ_ARRAY;
            fcsm_pkg::CMD_SUSPEND: idle_decode = fcsm_pkg::ST_READ_STATUS;
            fcsm_pkg::CMD_READ_STATUS: idle_decode = fcsm_pkg::ST_READ_STATUS;
            fcsm_pkg::CMD_READ_ID: idle_decode = fcsm_pkg::ST_READ_CONFIG;
            fcsm_pkg::CMD_READ_QUERY: idle_decode = fcsm_pkg::ST_READ_QUERY;
            fcsm_pkg::CMD_LOCK_SETUP: idle_decode = fcsm_pkg::ST_LOCK_SETUP;
            fcsm_pkg::CMD_OTP_SETUP: idle_decode = fcsm_pkg::ST_OTP_SETUP;
            default: idle_decode = cur;
        endcase
    endfunction : idle_decode

    // Read source chosen from the state the machine will sit in
    function automatic logic [1:0] src_of(input fcsm_pkg::fcsm_state_t st);
        case (st)
            fcsm_pkg::ST_READ_ARRAY: src_of = fcsm_pkg::SRC_ARRAY;
            fcsm_pkg::ST_READ_CONFIG: src_of = fcsm_pkg::SRC_CONFIG;
            fcsm_pkg::ST_READ_QUERY: src_of = fcsm_pkg::SRC_QUERY;
            default: src_of = fcsm_pkg::SRC_STATUS;
        endcase
    endfunction : src_of

    assign idle_nxt = idle_decode(CMD_DATA, state_r);
    assign lock_ok = (CMD_DATA == fcsm_pkg::CMD_CONFIRM) ||
                     (CMD_DATA == fcsm_pkg::CMD_LOCK_2ND_A) ||
                     (CMD_DATA == fcsm_pkg::CMD_LOCK_2ND_B) ||
                     (CMD_DATA == fcsm_pkg::CMD_LOCK_2ND_C);

    // ==========================================================
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            fcsm_pkg::ST_OTP_BUSY:
            begin
                if (timer_done) // RL1
                    state_nxt = fcsm_pkg::ST_OTP_DONE;
            end
            fcsm_pkg::ST_PROG_BUSY:
            begin
                if (CMD_WE && CMD_DATA == fcsm_pkg::CMD_SUSPEND) // RL6
                    state_nxt = fcsm_pkg::ST_PROG_SUSP;
                else if (timer_done)
                    state_nxt = fcsm_pkg::ST_PROG_DONE;
            end
            fcsm_pkg::ST_PROG_SUSP:
            begin
                if (CMD_WE && CMD_DATA == fcsm_pkg::CMD_CONFIRM)
                    state_nxt = fcsm_pkg::ST_PROG_BUSY;
            end
            fcsm_pkg::ST_OTP_SETUP:
            begin
                if (CMD_WE)
                    state_nxt = fcsm_pkg::ST_OTP_BUSY;
            end
            fcsm_pkg::ST_PROG_SETUP:
            begin
                if (CMD_WE)
                    state_nxt = fcsm_pkg::ST_PROG_BUSY;
            end
            fcsm_pkg::ST_LOCK_SETUP:
            begin
                if (CMD_WE) // RL4
                    state_nxt = lock_ok ? fcsm_pkg::ST_READ_STATUS : fcsm_pkg::ST_BOTCH;
            end
            fcsm_pkg::ST_BUF_SETUP, fcsm_pkg::ST_BFP_SETUP, fcsm_pkg::ST_ERASE_SETUP:
            begin
                // Their datapaths live elsewhere; a second cycle returns to status read
                if (CMD_WE)
                    state_nxt = fcsm_pkg::ST_READ_STATUS;
            end
            fcsm_pkg::ST_BOTCH:
            begin
                if (CMD_WE) // RL5
                    state_nxt = (CMD_DATA == fcsm_pkg::CMD_BUF_SETUP) ?
                                fcsm_pkg::ST_BOTCH : idle_nxt;
            end
            default:
            begin
                // Idle reads and both done states decode alike
                if (CMD_WE) // RL3
                    state_nxt = idle_nxt;
            end
        endcase
    end

    assign timer_start = (state_r == fcsm_pkg::ST_OTP_SETUP || state_r == fcsm_pkg::ST_PROG_SETUP)
                         && CMD_WE;
    // Freeze on the suspend edge too, so a suspend that lands on the last
    // busy cycle cannot drain the count to zero and hang the resumed program
    assign timer_hold = (state_r == fcsm_pkg::ST_PROG_SUSP) ||
                        (state_r == fcsm_pkg::ST_PROG_BUSY && CMD_WE &&
                         CMD_DATA == fcsm_pkg::CMD_SUSPEND);
    // Ready low only while an operation runs
    assign ready_nxt = !(state_nxt == fcsm_pkg::ST_OTP_BUSY || // RL2
                         state_nxt == fcsm_pkg::ST_PROG_BUSY);
    assign src_nxt = src_of(state_nxt); // RL1 RL5

    fcsm_busy_timer u_timer
    (
        .sys_clk(SYS_CLK),
        .resetn(RESETN),
        .start(timer_start),
        .hold(timer_hold),
        .done(timer_done)
    );

    // ==========================================================
    // State and output registers
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN) // RL7
        begin
            state_r <= fcsm_pkg::ST_READ_ARRAY;
            READ_SRC <= fcsm_pkg::SRC_ARRAY;
            READY <= fcsm_pkg::STATUS_RESET[fcsm_pkg::READY_BIT];
            BUF_PROG_STATUS <= fcsm_pkg::STATUS_RESET[fcsm_pkg::BUF_PROG_BIT];
            STATE <= 4'h0_0;
        end
        else
        begin
            state_r <= state_nxt;
            READ_SRC <= src_nxt;
            READY <= ready_nxt;
            // Don't-care while busy; driven low for a stable pin
            BUF_PROG_STATUS <= 1'b0;
            STATE <= state_nxt;
        end
    end

    // ==========================================================
    // Checks
    sequence s_otp_busy;
        state_r == fcsm_pkg::ST_OTP_BUSY && !timer_done;
    endsequence

    property p_otp_ignore;
        @(posedge SYS_CLK) disable iff (!RESETN)
        s_otp_busy |=> state_r == fcsm_pkg::ST_OTP_BUSY && READ_SRC == fcsm_pkg::SRC_STATUS;
    endproperty
    a_otp_ignore: assert property (p_otp_ignore) else $error("OTP busy left early"); // RL1

    property p_otp_ready;
        @(posedge SYS_CLK) disable iff (!RESETN)
        state_r == fcsm_pkg::ST_OTP_BUSY |-> !READY;
    endproperty
    a_otp_ready: assert property (p_otp_ready) else $error("Ready high in OTP busy"); // RL2

    property p_otp_done;
        @(posedge SYS_CLK) disable iff (!RESETN)
        state_r == fcsm_pkg::ST_OTP_DONE && CMD_WE && CMD_DATA == fcsm_pkg::CMD_BUF_SETUP
        |=> state_r == fcsm_pkg::ST_BUF_SETUP;
    endproperty
    a_otp_done: assert property (p_otp_done) else $error("OTP done decode wrong"); // RL3

    property p_lock_bad;
        @(posedge SYS_CLK) disable iff (!RESETN)
        state_r == fcsm_pkg::ST_LOCK_SETUP && CMD_WE && !lock_ok |=> state_r == fcsm_pkg::ST_BOTCH;
    endproperty
    a_lock_bad: assert property (p_lock_bad) else $error("Bad lock cycle not flagged"); // RL4

    property p_botch_stay;
        @(posedge SYS_CLK) disable iff (!RESETN)
        state_r == fcsm_pkg::ST_BOTCH && CMD_WE && CMD_DATA == fcsm_pkg::CMD_BUF_SETUP
        |=> state_r == fcsm_pkg::ST_BOTCH && READY && READ_SRC == fcsm_pkg::SRC_STATUS;
    endproperty
    a_botch_stay: assert property (p_botch_stay) else $error("Error state not held"); // RL5

    property p_prog_susp;
        @(posedge SYS_CLK) disable iff (!RESETN)
        state_r == fcsm_pkg::ST_PROG_BUSY && CMD_WE && CMD_DATA == fcsm_pkg::CMD_SUSPEND
        |=> state_r == fcsm_pkg::ST_PROG_SUSP && READY;
    endproperty
    a_prog_susp: assert property (p_prog_susp) else $error("Suspend not taken"); // RL6

    property p_prog_ignore;
        @(posedge SYS_CLK) disable iff (!RESETN)
        state_r == fcsm_pkg::ST_PROG_BUSY && CMD_DATA != fcsm_pkg::CMD_SUSPEND && !timer_done
        |=> state_r == fcsm_pkg::ST_PROG_BUSY;
    endproperty
    a_prog_ignore: assert property (p_prog_ignore) else $error("Program busy left"); // RL6

    property p_reset_idle;
        @(posedge SYS_CLK)
        !RESETN |=> state_r == fcsm_pkg::ST_READ_ARRAY && READY;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("Reset not idle"); // RL7

endmodule : fcsm_top
`default_nettype wire

// [testbench/fcsm_host_model.sv]
// Host memory controller model that issues flash command cycles
`timescale 1ns/1ps
`default_nettype none
module fcsm_host_model
(
    // Clock
    input wire logic sys_clk,
    // Command cycle outputs
    output var logic cmd_we,
    output var logic [7:0] cmd_data
);
    initial
    begin
        cmd_we = 1'b0;
        cmd_data = 8'h00;
    end

    // ==========================================================
    // One command cycle, launched and ended on the falling edge
    // The byte is not held after the cycle: the inverse shows up so a
    // stale value can never pass for a fresh one
    task automatic write_cmd(input logic [7:0] value);
        @(negedge sys_clk);
        cmd_we = 1'b1;
        cmd_data = value;
        @(negedge sys_clk);
        cmd_we = 1'b0;
        cmd_data = ~value;
    endtask : write_cmd

    // ==========================================================
    // Lock sequence: setup byte, then the chosen second cycle
    task automatic lock_seq(input logic [7:0] second);
        write_cmd(fcsm_pkg::CMD_LOCK_SETUP);
        write_cmd(second);
    endtask : lock_seq
endmodule : fcsm_host_model
`default_nettype wire

// [testbench/tb_fcsm_top.sv]
// Self-checking testbench of the flash command state machine
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
    begin \
        checks++; \
        if ((act) !== (exp)) \
        begin \
            fail_count++; \
            $display("unexpected at %0t ns: got %h expected %h", $time, (act), (exp)); \
        end \
    end
module tb_fcsm_top;
    logic sys_clk;
    logic resetn;
    wire logic cmd_we;
    wire logic [7:0] cmd_data;
    logic [1:0] read_src;
    logic ready;
    logic buf_prog_status;
    logic [3:0] state;
    int fail_count = 0;
    int checks = 0;

    // ==========================================================
    // Clock, host and design
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    fcsm_host_model host (.sys_clk(sys_clk), .cmd_we(cmd_we), .cmd_data(cmd_data));

    fcsm_top dut (.SYS_CLK(sys_clk), .RESETN(resetn), .CMD_WE(cmd_we), .CMD_DATA(cmd_data),
        .READ_SRC(read_src), .READY(ready), .BUF_PROG_STATUS(buf_prog_status), .STATE(state));

    // ==========================================================
    // Shared helpers
    task automatic summarize();
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // Buffered-program bit only matters while ready
    task automatic expect_out(input logic [3:0] st, input logic [1:0] src, input logic rdy);
        `CHK(state, st)
        `CHK(read_src, src)
        `CHK(ready, rdy)
        if (rdy === 1'b1)
            `CHK(buf_prog_status, 1'b0)
    endtask : expect_out

    task automatic do_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
    endtask : do_reset

    // Busy lasts 20 cycles; 40 is a generous bound
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 40)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(ready, 1'b1)
    endtask : wait_ready

    task automatic otp_to_done();
        host.write_cmd(fcsm_pkg::CMD_OTP_SETUP);
        host.write_cmd(8'h5A);
        wait_ready();
    endtask : otp_to_done

    // ==========================================================
    // Scenarios
    task automatic t_otp();
        host.write_cmd(fcsm_pkg::CMD_OTP_SETUP);
        expect_out(fcsm_pkg::ST_OTP_SETUP, fcsm_pkg::SRC_STATUS, 1'b1);
        host.write_cmd(8'h5A);
        expect_out(fcsm_pkg::ST_OTP_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        host.write_cmd(fcsm_pkg::CMD_READ_ARRAY);
        expect_out(fcsm_pkg::ST_OTP_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        host.write_cmd(fcsm_pkg::CMD_SUSPEND);
        expect_out(fcsm_pkg::ST_OTP_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        wait_ready();
        expect_out(fcsm_pkg::ST_OTP_DONE, fcsm_pkg::SRC_STATUS, 1'b1);
    endtask : t_otp

    task automatic t_otp_done_decode();
        logic [7:0] codes [4];
        logic [3:0] nxt [4];
        codes = '{fcsm_pkg::CMD_READ_ARRAY, fcsm_pkg::CMD_PROG_SETUP_A,
            fcsm_pkg::CMD_PROG_SETUP_B, fcsm_pkg::CMD_BUF_SETUP};
        nxt = '{fcsm_pkg::ST_READ_ARRAY, fcsm_pkg::ST_PROG_SETUP,
            fcsm_pkg::ST_PROG_SETUP, fcsm_pkg::ST_BUF_SETUP};
        for (int i = 0; i < 4; i++)
        begin
            do_reset();
            otp_to_done();
            host.write_cmd(codes[i]);
            expect_out(nxt[i], (i == 0) ? fcsm_pkg::SRC_ARRAY : fcsm_pkg::SRC_STATUS, 1'b1);
        end
    endtask : t_otp_done_decode

    task automatic t_lock();
        logic [7:0] good [4];
        good = '{fcsm_pkg::CMD_CONFIRM, fcsm_pkg::CMD_LOCK_2ND_A,
            fcsm_pkg::CMD_LOCK_2ND_B, fcsm_pkg::CMD_LOCK_2ND_C};
        do_reset();
        host.write_cmd(fcsm_pkg::CMD_LOCK_SETUP);
        expect_out(fcsm_pkg::ST_LOCK_SETUP, fcsm_pkg::SRC_STATUS, 1'b1);
        host.write_cmd(good[0]);
        expect_out(fcsm_pkg::ST_READ_STATUS, fcsm_pkg::SRC_STATUS, 1'b1);
        for (int i = 1; i < 4; i++)
        begin
            host.lock_seq(good[i]);
            expect_out(fcsm_pkg::ST_READ_STATUS, fcsm_pkg::SRC_STATUS, 1'b1);
        end
        host.lock_seq(8'h55);
        expect_out(fcsm_pkg::ST_BOTCH, fcsm_pkg::SRC_STATUS, 1'b1);
        host.write_cmd(fcsm_pkg::CMD_BUF_SETUP);
        expect_out(fcsm_pkg::ST_BOTCH, fcsm_pkg::SRC_STATUS, 1'b1);
        host.write_cmd(fcsm_pkg::CMD_READ_ARRAY);
        expect_out(fcsm_pkg::ST_READ_ARRAY, fcsm_pkg::SRC_ARRAY, 1'b1);
        host.lock_seq(fcsm_pkg::CMD_LOCK_SETUP);
        host.write_cmd(fcsm_pkg::CMD_PROG_SETUP_B);
        expect_out(fcsm_pkg::ST_PROG_SETUP, fcsm_pkg::SRC_STATUS, 1'b1);
    endtask : t_lock

    // Error state decodes ID, query, status, 30, 20 and D0 as an idle read state would
    task automatic t_error_decode();
        logic [7:0] codes [6];
        logic [3:0] nxt [6];
        logic [1:0] src [6];
        codes = '{fcsm_pkg::CMD_READ_ID, fcsm_pkg::CMD_READ_QUERY, fcsm_pkg::CMD_READ_STATUS,
            fcsm_pkg::CMD_BFP_SETUP, fcsm_pkg::CMD_ERASE_SETUP, fcsm_pkg::CMD_CONFIRM};
        nxt = '{fcsm_pkg::ST_READ_CONFIG, fcsm_pkg::ST_READ_QUERY, fcsm_pkg::ST_READ_STATUS,
            fcsm_pkg::ST_BFP_SETUP, fcsm_pkg::ST_ERASE_SETUP, fcsm_pkg::ST_READ_ARRAY};
        src = '{fcsm_pkg::SRC_CONFIG, fcsm_pkg::SRC_QUERY, fcsm_pkg::SRC_STATUS,
            fcsm_pkg::SRC_STATUS, fcsm_pkg::SRC_STATUS, fcsm_pkg::SRC_ARRAY};
        for (int i = 0; i < 6; i++)
        begin
            do_reset();
            host.lock_seq(8'hAA);
            host.write_cmd(codes[i]);
            expect_out(nxt[i], src[i], 1'b1);
        end
    endtask : t_error_decode

    task automatic t_prog();
        do_reset();
        host.write_cmd(fcsm_pkg::CMD_PROG_SETUP_B);
        host.write_cmd(8'hA5);
        expect_out(fcsm_pkg::ST_PROG_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        host.write_cmd(fcsm_pkg::CMD_READ_ARRAY);
        host.write_cmd(fcsm_pkg::CMD_CONFIRM);
        expect_out(fcsm_pkg::ST_PROG_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        host.write_cmd(fcsm_pkg::CMD_SUSPEND);
        expect_out(fcsm_pkg::ST_PROG_SUSP, fcsm_pkg::SRC_STATUS, 1'b1);
        host.write_cmd(fcsm_pkg::CMD_CONFIRM);
        expect_out(fcsm_pkg::ST_PROG_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        wait_ready();
        expect_out(fcsm_pkg::ST_PROG_DONE, fcsm_pkg::SRC_STATUS, 1'b1);
        // Second program, cut short by a reset while busy
        host.write_cmd(fcsm_pkg::CMD_PROG_SETUP_A);
        host.write_cmd(8'h3C);
        expect_out(fcsm_pkg::ST_PROG_BUSY, fcsm_pkg::SRC_STATUS, 1'b0);
        @(negedge sys_clk);
        resetn = 1'b0;
        #2;
        expect_out(fcsm_pkg::ST_READ_ARRAY, fcsm_pkg::SRC_ARRAY, 1'b1);
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        expect_out(fcsm_pkg::ST_READ_ARRAY, fcsm_pkg::SRC_ARRAY, 1'b1);
    endtask : t_prog

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        resetn = 1'b0;
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        expect_out(fcsm_pkg::ST_READ_ARRAY, fcsm_pkg::SRC_ARRAY, 1'b1);
        t_otp();
        t_otp_done_decode();
        t_lock();
        t_error_decode();
        t_prog();
        summarize();
    end

    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule : tb_fcsm_top
`default_nettype wire
